// file: genlock_mode_ctrl.sv
// Operating mode control, pin following, reference validity and ten-field handling.
`timescale 1ns/1ns
module genlock_mode_ctrl
  import genlock_pkg::*;
#(
  parameter int unsigned P_H_MAX_CYC    = H_MAX_CYC,
  parameter int unsigned P_V_MIN_CYC    = V_MIN_CYC,
  parameter int unsigned P_V_MAX_CYC    = V_MAX_CYC,
  parameter int unsigned P_RATE_SPL_CYC = RATE_SPLIT_CYC
) (
  // Clock and reset.
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_sys_rst,
  // Strap and mode pins.
  input  wire logic                     i_lock_select,
  input  wire logic [5:0]               i_output_format_select,
  input  wire logic [2:0]               i_audio_rate_select,
  // Sync reference inputs.
  input  wire logic                     i_hsync_ref,
  input  wire logic                     i_vsync_ref,
  input  wire logic                     i_field_reference_in,
  input  wire logic                     i_ten_field_id,
  // Line 1 leading edge of the generated H sync.
  input  wire logic                     i_line1_hsync_lead,
  // Register port.
  input  wire genlock_pkg::reg_req_type i_reg_req,
  output logic [15:0]                   o_reg_rdata,
  // Mode steering and followed pin settings.
  output genlock_pkg::mode_ctrl_type    o_mode_ctrl,
  output logic [5:0]                    o_output_format_select,
  output logic [2:0]                    o_audio_rate_select,
  output logic                          o_format_changed,
  // Divider and phase events.
  output logic                          o_ten_field_id_div_reset,
  output logic                          o_audio_frame_sequence_reset,
  output logic                          o_audio_phase_realign
);

  // Period limits cut to counter width.
  localparam logic [CNT_W-1:0] LIM_H_MIN = CNT_W'(H_MIN_CYC);
  localparam logic [CNT_W-1:0] LIM_H_MAX = CNT_W'(P_H_MAX_CYC);
  localparam logic [CNT_W-1:0] LIM_V_MIN = CNT_W'(P_V_MIN_CYC);
  localparam logic [CNT_W-1:0] LIM_V_MAX = CNT_W'(P_V_MAX_CYC);
  localparam logic [CNT_W-1:0] LIM_SPLIT = CNT_W'(P_RATE_SPL_CYC);

  // All state of the controller.
  typedef struct packed {
    mode_type    mode;
    logic [1:0]  miss;
    logic        ref_missing;
    logic [5:0]  fmt;
    logic [2:0]  rate;
    logic        fmt_changed;
    logic        tfid_prev;
    logic        tfid_rst;
    logic        afs_rst;
    logic        realign;
    logic        field_lvl;
    logic [47:0] mask;
    logic        hd_on;
    logic        afs_en;
    logic [15:0] rdata;
  } core_state_type;

  core_state_type   s_q;
  core_state_type   s_d;
  logic             h_pol_neg;     // Line sync is active low.
  logic             v_pol_neg;     // Frame sync is active low.
  logic             h_lead;        // Line leading edge pulse.
  logic             v_lead;        // Frame leading edge pulse.
  logic [CNT_W-1:0] h_active;      // Active width of the line pulse.
  logic [CNT_W-1:0] h_period;      // Last line period in cycles.
  logic [CNT_W-1:0] v_period;      // Last frame period in cycles.
  logic             h_seen;        // Line pulses are arriving.
  logic             v_seen;        // Frame pulses are arriving.
  logic             h_timeout;     // A line pulse went missing.
  logic             sd_valid;      // Standard-definition windows met.
  logic             hd_like;       // Line period too short for standard definition.
  logic             hd_ok;         // HD reference accepted.
  logic             recognized;    // Reference usable for lock.
  logic             rate_1001;     // Frame period of the 1.001 family.
  logic             digital;       // Blanking style timing detected.
  logic [15:0]      report;        // Input sync report word.

  // Inclusive window check shared by the line and frame tests.
  function automatic logic in_range(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lo,
                                    input logic [CNT_W-1:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Blanking pulses are wide; a pulse above an eighth of the line is taken as digital timing.
  function automatic logic wide_pulse(input logic [CNT_W-1:0] width, input logic [CNT_W-1:0] period);
    wide_pulse = {width, 3'b000} > {3'b000, period};
  endfunction

  // Polarity and leading edge finders for the line and frame inputs.
  sync_edge_detect u_h_edge (
    .i_ref_clk    (i_ref_clk),
    .i_sys_rst    (i_sys_rst),
    .i_sync       (i_hsync_ref),
    .o_pol_neg    (h_pol_neg),
    .o_lead       (h_lead),
    .o_active_len (h_active)
  );

  sync_edge_detect u_v_edge (
    .i_ref_clk    (i_ref_clk),
    .i_sys_rst    (i_sys_rst),
    .i_sync       (i_vsync_ref),
    .o_pol_neg    (v_pol_neg),
    .o_lead       (v_lead),
    .o_active_len ()
  );

  // Period meters; the line meter's timeout marks each missing line pulse.
  period_meter u_h_meter (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_lead    (h_lead),
    .i_limit   (LIM_H_MAX),
    .o_period  (h_period),
    .o_seen    (h_seen),
    .o_timeout (h_timeout)
  );

  period_meter u_v_meter (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_lead    (v_lead),
    .i_limit   (LIM_V_MAX),
    .o_period  (v_period),
    .o_seen    (v_seen),
    .o_timeout ()
  );

  // Reference classification; SD needs no setup, HD needs an enabled mask bit and the enable.
  always_comb begin
    sd_valid   = h_seen && v_seen && (s_q.miss == 2'h0) && in_range(h_period, LIM_H_MIN, LIM_H_MAX)
                 && in_range(v_period, LIM_V_MIN, LIM_V_MAX);
    hd_like    = h_seen && (s_q.miss == 2'h0) && (h_period < LIM_H_MIN);
    hd_ok      = hd_like && s_q.hd_on && !(&s_q.mask[HD_MASK_MSB:HD_MASK_LSB]);
    recognized = sd_valid || hd_ok;
    rate_1001  = v_period > LIM_SPLIT;
    digital    = wide_pulse(h_active, h_period);
  end

  // Report word with polarity, timing style, validity and current mode.
  always_comb begin
    report                  = 16'h0000;
    report[RPT_VALID_BIT]   = recognized;
    report[RPT_1001_BIT]    = rate_1001;
    report[RPT_DIGITAL_BIT] = digital;
    report[RPT_HPOL_BIT]    = h_pol_neg;
    report[RPT_VPOL_BIT]    = v_pol_neg;
    report[RPT_HD_BIT]      = hd_ok;
    report[RPT_FIELD_BIT]   = s_q.field_lvl;
    report[RPT_MODE_LSB +: 5] = s_q.mode;
  end

  // Next state: mode machine, missing pulse count, pin following, events and registers.
  always_comb begin
    s_d             = s_q;
    s_d.fmt_changed = 1'b0;
    s_d.tfid_rst    = 1'b0;
    s_d.afs_rst     = 1'b0;
    s_d.realign     = 1'b0;
    s_d.field_lvl   = i_field_reference_in;
    s_d.tfid_prev   = i_ten_field_id;

    // A line edge clears the count; each timeout adds one, saturating at the limit.
    if (h_lead) begin
      s_d.miss = 2'h0;
    end else if (h_timeout && (s_q.miss != MISS_LIMIT)) begin
      s_d.miss = s_q.miss + 2'h1;
    end
    // The missing flag rises with the second lost pulse and falls once a reference is usable.
    if (s_d.miss == MISS_LIMIT) begin
      s_d.ref_missing = 1'b1;
    end else if (recognized) begin
      s_d.ref_missing = 1'b0;
    end

    // Mode machine.
    case (s_q.mode)
      ST_START: begin
        // First cycle after release: the strap decides between free-run and acquisition.
        s_d.mode = i_lock_select ? ST_FREE : ST_ACQ;
      end
      ST_FREE: begin
        if (!i_lock_select) begin
          s_d.mode = ST_ACQ;
        end
      end
      ST_ACQ: begin
        // Lock only on a recognized reference; no timeout, acquisition waits as long as it takes.
        if (recognized) begin
          s_d.mode = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (s_d.miss == MISS_LIMIT) begin
          s_d.mode = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Re-acquire through the normal path once a recognized reference returns.
        if (recognized) begin
          s_d.mode = ST_ACQ;
        end
      end
      default: begin
        s_d.mode = ST_START;
      end
    endcase
    // The lock-select pin overrides every mode once running.
    if ((s_q.mode != ST_START) && i_lock_select) begin
      s_d.mode = ST_FREE;
    end

    // Pins are followed every cycle after the start state; upper format bits are passed as the host ties them.
    if (s_q.mode != ST_START) begin
      s_d.fmt         = i_output_format_select;
      s_d.rate        = i_audio_rate_select;
      s_d.fmt_changed = (i_output_format_select != s_q.fmt);
    end

    // Ten-field rising edge resets its divider and, if enabled, the frame sequence divider.
    if (i_ten_field_id && !s_q.tfid_prev) begin
      s_d.tfid_rst = 1'b1;
      s_d.afs_rst  = s_q.afs_en;
    end
    // Audio phase realigns at line 1 of frames where the ten-field input is high.
    s_d.realign = i_line1_hsync_lead && i_ten_field_id;

    // Register writes.
    if (i_reg_req.wr_en) begin
      case (i_reg_req.addr)
        REG_FMT_MASK0:  s_d.mask[15:0]  = i_reg_req.wdata;
        REG_FMT_MASK1:  s_d.mask[31:16] = i_reg_req.wdata;
        REG_FMT_MASK2:  s_d.mask[47:32] = i_reg_req.wdata;
        REG_HD_CTRL:    s_d.hd_on       = i_reg_req.wdata[HD_ON_BIT];
        REG_AUDIO_CTRL: s_d.afs_en      = i_reg_req.wdata[AFS_RST_BIT];
        default:        s_d.mask        = s_q.mask;
      endcase
    end
    // Register reads are registered; unmapped offsets read zero.
    if (i_reg_req.rd_en) begin
      case (i_reg_req.addr)
        REG_FMT_MASK0:   s_d.rdata = s_q.mask[15:0];
        REG_FMT_MASK1:   s_d.rdata = s_q.mask[31:16];
        REG_FMT_MASK2:   s_d.rdata = s_q.mask[47:32];
        REG_HD_CTRL:     s_d.rdata = {8'h00, s_q.hd_on, 7'h00};
        REG_SYNC_REPORT: s_d.rdata = report;
        REG_AUDIO_CTRL:  s_d.rdata = {15'h0000, s_q.afs_en};
        default:         s_d.rdata = 16'h0000;
      endcase
    end
  end

  // State register with constant reset values.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q        <= '0;
      s_q.mode   <= ST_START;
      s_q.mask   <= FMT_MASK_RST;
      s_q.hd_on  <= HD_ON_RST;
      s_q.afs_en <= AFS_RST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Mode steering: holdover freezes the loop while the crystal still sets the timebase.
  always_comb begin
    o_mode_ctrl.timebase_from_ref  = (s_q.mode == ST_LOCK);
    o_mode_ctrl.freeze_freq        = (s_q.mode == ST_HOLD);
    o_mode_ctrl.crystal_only       = (s_q.mode == ST_FREE) || (s_q.mode == ST_HOLD);
    o_mode_ctrl.audio_enable       = (s_q.rate != AUDIO_OFF_CODE);
    o_mode_ctrl.audio_follow_video = 1'b1;
    o_mode_ctrl.ref_missing        = s_q.ref_missing;
    o_mode_ctrl.lock_lost          = (s_q.mode != ST_LOCK) || (s_q.miss != 2'h0);
  end

  assign o_reg_rdata                  = s_q.rdata;
  assign o_output_format_select       = s_q.fmt;
  assign o_audio_rate_select          = s_q.rate;
  assign o_format_changed             = s_q.fmt_changed;
  assign o_ten_field_id_div_reset     = s_q.tfid_rst;
  assign o_audio_frame_sequence_reset = s_q.afs_rst;
  assign o_audio_phase_realign        = s_q.realign;

  // Checks on the controller.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  AST_HOLD_ON_LOSS: assert property ((s_q.mode == ST_LOCK) && (s_q.miss == 2'h1) && h_timeout && !h_lead
    && !i_lock_select |=> (s_q.mode == ST_HOLD) && o_mode_ctrl.ref_missing && o_mode_ctrl.lock_lost)
    else $error("lock not dropped to holdover after two missing pulses");
  AST_HOLD_FREEZE: assert property ((s_q.mode == ST_HOLD) |-> o_mode_ctrl.freeze_freq
    && o_mode_ctrl.crystal_only && !o_mode_ctrl.timebase_from_ref)
    else $error("holdover without frozen crystal timebase");
  AST_FREE_ON_PIN: assert property ((s_q.mode != ST_START) && i_lock_select |=> (s_q.mode == ST_FREE)
    && o_mode_ctrl.crystal_only)
    else $error("lock select high did not force free-running");
  AST_STRAP: assert property ((s_q.mode == ST_START) |=> ((s_q.mode == ST_FREE) == $past(i_lock_select)))
    else $error("power-up mode does not match sampled strap");
  AST_FOLLOW: assert property ((s_q.mode != ST_START) |=> (o_output_format_select == $past(i_output_format_select))
    && (o_audio_rate_select == $past(i_audio_rate_select)))
    else $error("select pins not followed");
  AST_AUDIO_OFF: assert property (o_mode_ctrl.audio_enable == (o_audio_rate_select != AUDIO_OFF_CODE))
    else $error("audio enable disagrees with rate select");
  AST_LOCK_NEEDS_REF: assert property ($rose(s_q.mode == ST_LOCK) |-> $past(recognized)
    && $past(s_q.mode == ST_ACQ))
    else $error("lock entered without recognized reference");
  AST_TFID_RESET: assert property ($rose(i_ten_field_id) |=> o_ten_field_id_div_reset
    && (o_audio_frame_sequence_reset == $past(s_q.afs_en)) ##1 !o_ten_field_id_div_reset)
    else $error("ten-field divider reset wrong");
  AST_REALIGN: assert property (i_line1_hsync_lead && i_ten_field_id |=> o_audio_phase_realign)
    else $error("audio phase not realigned on line 1");
  AST_LOCK_TIMEBASE: assert property ((s_q.mode == ST_LOCK) |-> o_mode_ctrl.timebase_from_ref
    && !o_mode_ctrl.crystal_only && !o_mode_ctrl.freeze_freq)
    else $error("locked mode not using reference timebase");
  AST_SD_WINDOW: assert property (sd_valid |-> (h_period >= LIM_H_MIN) && (v_period <= LIM_V_MAX))
    else $error("standard-definition validity outside windows");

  // Further checks on loss handling, pin following, the report and the audio phase; each
  // compares what the controller drives with the inputs and internal state that caused it.
  // One lost line pulse only flags lock loss; the second one is needed for holdover.
  AST_ONE_MISS: assert property ((s_q.mode == ST_LOCK) && (s_q.miss == 2'h0) && h_timeout && !h_lead
    && !i_lock_select |=> (s_q.mode == ST_LOCK) && o_mode_ctrl.lock_lost && !o_mode_ctrl.ref_missing)
    else $error("single missing pulse handled wrongly");
  // A change on the format pins is flagged in the same cycle as it is copied.
  AST_FMT_CHANGED: assert property ((s_q.mode != ST_START)
    && (i_output_format_select != o_output_format_select) |=> o_format_changed)
    else $error("format change not flagged");
  // The report carries the polarity that the finders held when the read was taken.
  AST_REPORT_POL: assert property (i_reg_req.rd_en && (i_reg_req.addr == REG_SYNC_REPORT)
    |=> (o_reg_rdata[RPT_HPOL_BIT] == $past(h_pol_neg)) && (o_reg_rdata[RPT_VPOL_BIT] == $past(v_pol_neg)))
    else $error("sync polarity report wrong");
  // A realign pulse needs a line 1 edge while the ten-field input was high.
  AST_REALIGN_CAUSE: assert property (o_audio_phase_realign
    |-> $past(i_ten_field_id) && $past(i_line1_hsync_lead))
    else $error("audio phase realigned without line 1 ten-field event");

endmodule

// file: genlock_pkg.sv
// Shared constants, register map and carrier types of the genlock mode and reference front end.
package genlock_pkg;

  // Clock rate of the design clock.
  localparam int          CLK_MHZ         = 125;
  // Width of every period counter, enough for the longest frame window.
  localparam int          CNT_W           = 22;

  // Validity windows as printed, and their cycle counts.
  localparam int          H_MIN_NS        = 29660;
  localparam int          H_MAX_NS        = 70000;
  localparam int          V_MIN_US        = 16000;
  localparam int          V_MAX_US        = 25000;
  localparam int          RATE_SPLIT_NS   = 16675008;
  localparam int          H_MIN_CYC       = (H_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int          H_MAX_CYC       = (H_MAX_NS * CLK_MHZ) / 1000;
  localparam int          V_MIN_CYC       = V_MIN_US * CLK_MHZ;
  localparam int          V_MAX_CYC       = V_MAX_US * CLK_MHZ;
  localparam int          RATE_SPLIT_CYC  = (RATE_SPLIT_NS / 1000) * CLK_MHZ;
  // Consecutive missing line pulses that declare the reference lost.
  localparam logic [1:0]  MISS_LIMIT      = 2'h2;

  // Register offsets.
  localparam logic [7:0]  REG_FMT_MASK0   = 8'h11;
  localparam logic [7:0]  REG_FMT_MASK1   = 8'h12;
  localparam logic [7:0]  REG_FMT_MASK2   = 8'h13;
  localparam logic [7:0]  REG_HD_CTRL     = 8'h82;
  localparam logic [7:0]  REG_SYNC_REPORT = 8'h20;
  localparam logic [7:0]  REG_AUDIO_CTRL  = 8'h21;

  // Field positions.
  localparam int          HD_ON_BIT       = 7;
  localparam int          AFS_RST_BIT     = 0;
  localparam int          RPT_VALID_BIT   = 0;
  localparam int          RPT_1001_BIT    = 1;
  localparam int          RPT_DIGITAL_BIT = 2;
  localparam int          RPT_HPOL_BIT    = 3;
  localparam int          RPT_VPOL_BIT    = 4;
  localparam int          RPT_HD_BIT      = 5;
  localparam int          RPT_FIELD_BIT   = 6;
  localparam int          RPT_MODE_LSB    = 8;
  localparam int          HD_MASK_LSB     = 10;
  localparam int          HD_MASK_MSB     = 37;

  // Reset values: standard definition enabled, every HD code disabled.
  localparam logic [47:0] FMT_MASK_RST    = 48'h003f_ffff_fc00;
  localparam logic        HD_ON_RST       = 1'b0;
  localparam logic        AFS_RST_RST     = 1'b1;

  // Audio rate select code that switches audio generation off.
  localparam logic [2:0]  AUDIO_OFF_CODE  = 3'h7;

  // Operating modes, one-hot.
  typedef enum logic [4:0] {
    ST_START = 5'h01,
    ST_FREE  = 5'h02,
    ST_ACQ   = 5'h04,
    ST_LOCK  = 5'h08,
    ST_HOLD  = 5'h10
  } mode_type;

  // Steering bits handed to the clock synthesis.
  typedef struct packed {
    logic timebase_from_ref;
    logic freeze_freq;
    logic crystal_only;
    logic audio_enable;
    logic audio_follow_video;
    logic ref_missing;
    logic lock_lost;
  } mode_ctrl_type;

  // Register port request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr_en;
    logic        rd_en;
  } reg_req_type;

endpackage

// file: sync_edge_detect.sv
// Polarity recognition and leading edge pulse for one sync reference input.
`timescale 1ns/1ns
module sync_edge_detect
  import genlock_pkg::*;
(
  // Clock and reset.
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  // Sync level.
  input  wire logic             i_sync,
  // Results.
  output logic                  o_pol_neg,
  output logic                  o_lead,
  output logic [CNT_W-1:0]      o_active_len
);

  // All state of the detector.
  typedef struct packed {
    logic             prev;
    logic [CNT_W-1:0] run;
    logic [CNT_W-1:0] hi_len;
    logic [CNT_W-1:0] lo_len;
    logic             lead;
    logic             armed;
  } edge_state_type;

  edge_state_type s_q;
  edge_state_type s_d;
  logic           pol_neg;

  // The shorter level is the pulse; polarity is negative when high lasts longer.
  assign pol_neg = s_q.hi_len > s_q.lo_len;

  // Measure each run of constant level and flag the entry into the active level.
  always_comb begin
    s_d      = s_q;
    s_d.prev = i_sync;
    s_d.lead = 1'b0;
    // The first sample after reset only loads the level, so an idle-high pin gives no false edge.
    s_d.armed = 1'b1;
    if (s_q.armed && (i_sync != s_q.prev)) begin
      // A transition closes the run of the previous level.
      if (s_q.prev) begin
        s_d.hi_len = s_q.run;
      end else begin
        s_d.lo_len = s_q.run;
      end
      s_d.run  = '0;
      // Leading edge is the move into the active level, for either polarity.
      s_d.lead = (i_sync != pol_neg);
    end else if (s_q.run != '1) begin
      // Saturate so a stuck input never wraps into a false short run.
      s_d.run = s_q.run + 1'b1;
    end
  end

  // State register.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_pol_neg    = pol_neg;
  assign o_lead       = s_q.lead;
  assign o_active_len = pol_neg ? s_q.lo_len : s_q.hi_len;

endmodule

// file: period_meter.sv
// Period measurement between leading edges with a timeout for missing pulses.
`timescale 1ns/1ns
module period_meter
  import genlock_pkg::*;
(
  // Clock and reset.
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  // Leading edge pulse and the longest period allowed.
  input  wire logic             i_lead,
  input  wire logic [CNT_W-1:0] i_limit,
  // Results.
  output logic [CNT_W-1:0]      o_period,
  output logic                  o_seen,
  output logic                  o_timeout
);

  // All state of the meter.
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period;
    logic             seen;
    logic             timeout;
  } meter_state_type;

  meter_state_type s_q;
  meter_state_type s_d;

  // Count cycles; an edge stores the period, an overlong gap raises a timeout and restarts.
  always_comb begin
    s_d         = s_q;
    s_d.timeout = 1'b0;
    if (i_lead) begin
      s_d.period = s_q.cnt + 1'b1;
      s_d.cnt    = '0;
      s_d.seen   = 1'b1;
    end else if (s_q.cnt >= i_limit) begin
      // Restarting lets consecutive missing pulses be counted one by one.
      s_d.timeout = 1'b1;
      s_d.cnt     = '0;
      s_d.seen    = 1'b0;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  // State register.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_period  = s_q.period;
  assign o_seen    = s_q.seen;
  assign o_timeout = s_q.timeout;

endmodule

// file: sync_ref_model.sv
// Sync reference source: active-low H and V pulses on a fixed raster.
`timescale 1ns/1ns
module sync_ref_model #(
  parameter int P_LINE  = 3800,
  parameter int P_LINES = 5
) (
  input  wire logic i_ref_clk,
  input  wire logic i_run,
  output logic      o_hsync,
  output logic      o_vsync,
  output logic      o_field
);
  int h_q = 0;
  int l_q = 0;
  // Raster counters run freely; only the pulses stop when the source is removed.
  always @(posedge i_ref_clk) begin
    h_q <= (h_q + 1) % P_LINE;
    if (h_q == P_LINE - 1) begin
      l_q <= (l_q + 1) % P_LINES;
    end
  end
  // Active-low pulses make the detector find the polarity itself.
  assign o_hsync = !(i_run && h_q < 280);
  assign o_vsync = !(i_run && l_q == 0);
  // This format has no field signal, so the line stays low.
  assign o_field = 1'b0;
endmodule

// file: genlock_mode_ctrl_tb_top.sv
// Self-checking bench for the mode control and reference front end.
`timescale 1ns/1ns
module genlock_mode_ctrl_tb_top;
  import genlock_pkg::*;
  logic clk = 0, rst = 1, lsel = 0, tf = 0, l1 = 0, run = 0, sd, sa, sr, sc, chg, dr, ar, re, hs, vs, fl;
  logic [5:0] fmt = 6'h03, fo;
  logic [2:0] asr = 3'h0, ao;
  reg_req_type req = '0;
  logic [15:0] rd;
  mode_ctrl_type mc;
  int err_count = 0, total_checks = 0, i;
  // Shortened windows keep a full lock within the run time.
  genlock_mode_ctrl #(.P_H_MAX_CYC(4000), .P_V_MIN_CYC(15000), .P_V_MAX_CYC(25000), .P_RATE_SPL_CYC(17000))
  u_genlock_mode_ctrl (.i_ref_clk(clk), .i_sys_rst(rst), .i_lock_select(lsel), .i_output_format_select(fmt),
    .i_audio_rate_select(asr), .i_hsync_ref(hs), .i_vsync_ref(vs), .i_field_reference_in(fl),
    .i_ten_field_id(tf), .i_line1_hsync_lead(l1), .i_reg_req(req), .o_reg_rdata(rd), .o_mode_ctrl(mc),
    .o_output_format_select(fo), .o_audio_rate_select(ao), .o_format_changed(chg),
    .o_ten_field_id_div_reset(dr), .o_audio_frame_sequence_reset(ar), .o_audio_phase_realign(re));
  sync_ref_model u_sync_ref_model (.i_ref_clk(clk), .i_run(run), .o_hsync(hs), .o_vsync(vs), .o_field(fl));
  initial forever #4 clk = ~clk;
  // Sticky event flags, since the event pulses are only one cycle wide.
  always @(posedge clk) begin
    sd |= dr;
    sa |= ar;
    sr |= re;
    sc |= chg;
  end
  task automatic chk(input string w, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask
  // One register access; read data is settled when the task returns.
  task automatic acc(input logic [7:0] a, input logic [15:0] d, input logic w);
    @(posedge clk) #1 req = '{a, d, w, !w};
    @(posedge clk) #1 req = '0;
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #800000 err_count++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 chk("lock_lost", mc.lock_lost, 1);
    rst = 0;
    acc(REG_SYNC_REPORT, 0, 0);
    chk("mode", rd[12:8], 5'h04);
    acc(REG_FMT_MASK0, 0, 0);
    chk("mask", rd, FMT_MASK_RST[15:0]);
    acc(REG_HD_CTRL, 16'h0080, 1);
    acc(REG_HD_CTRL, 0, 0);
    chk("hd_on", rd[HD_ON_BIT], 1);
    acc(8'h55, 16'h1234, 1);
    acc(8'h55, 0, 0);
    chk("unmapped", rd, 0);
    sc = 0;
    fmt = 6'h0a;
    asr = AUDIO_OFF_CODE;
    repeat (3) @(posedge clk);
    #1 chk("fmt", fo, 6'h0a);
    chk("fmt_changed", sc, 1);
    chk("rate", ao, AUDIO_OFF_CODE);
    chk("audio", mc.audio_enable, 0);
    for (i = 0; i < 2; i++) begin
      {sd, sa, sr} = 0;
      tf = 1;
      @(posedge clk) #1 l1 = 1;
      @(posedge clk) #1 l1 = 0;
      repeat (2) @(posedge clk);
      #1 chk("div", sd, 1);
      chk("afs", sa, !i);
      chk("phase", sr, 1);
      tf = 0;
      acc(REG_AUDIO_CTRL, 0, 1);
    end
    run = 1;
    for (i = 0; i < 80000 && mc.lock_lost !== 1'b0; i++) @(posedge clk);
    acc(REG_SYNC_REPORT, 0, 0);
    chk("report", rd & 16'h1f7f, 16'h081b);
    chk("timebase", mc.timebase_from_ref, 1);
    run = 0;
    repeat (8100) @(posedge clk);
    #1 chk("missing", {mc.ref_missing, mc.freeze_freq}, 2'h3);
    lsel = 1;
    repeat (2) @(posedge clk);
    #1 chk("free", {mc.crystal_only, mc.audio_follow_video}, 2'h3);
    give_verdict();
  end
endmodule
